// [hw/uic_pkg.sv]
package uic_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TXDATA = 8'h08;
  localparam logic [7:0] OFF_RXDATA = 8'h0c;
  localparam logic [7:0] OFF_BAUD = 8'h10;

  // serial_mode_control field positions
  localparam int MODE_EN = 15;
  localparam int MODE_SIDL = 13;
  localparam int MODE_INFRARED_CODEC_ENABLE = 12;
  localparam int MODE_RTS_MODE_SELECT = 11;
  localparam int MODE_UEN = 8;
  localparam int MODE_WAKE = 7;
  localparam int MODE_LOOPBACK_SELECT = 6;
  localparam int MODE_AUTO_BAUD_ENABLE = 5;
  localparam int MODE_RECEIVE_INVERSION = 4;
  localparam int MODE_HIGH_SPEED_SELECT = 3;
  localparam int MODE_PARITY_DATA_SELECT = 1;
  localparam int MODE_STOP_BIT_SELECT = 0;
  localparam logic [15:0] MODE_WMASK = 16'hbbff;

  // serial_status_control field positions
  localparam int STA_TXISEL1 = 15;
  localparam int STA_TXINV = 14;
  localparam int STA_TXISEL0 = 13;
  localparam int STA_BRK = 11;
  localparam int STA_TXEN = 10;
  localparam int STA_RXISEL = 6;
  localparam int STA_ADDRESS_DETECT_ENABLE = 5;
  localparam int STA_OVERRUN_ERROR = 1;
  localparam logic [15:0] STA_WMASK = 16'hece0;

  // reset values
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] STA_RST = 16'h0000;
  localparam logic [15:0] BAUD_RST = 16'h0000;

  // timing counts in baud ticks and bits
  localparam logic [4:0] OS_STD = 5'h10;
  localparam logic [4:0] OS_HS = 5'h04;
  localparam logic [4:0] IR_PULSE = 5'h03;
  localparam logic [3:0] BREAK_BITS = 4'hc;
  localparam logic [2:0] SYNC_FALLS = 3'h5;
  localparam logic [15:0] SYNC_CHAR = 16'h0055;

  // apb request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } uic_apb_t;

  // one receive fifo entry with its own error flags
  typedef struct packed {
    logic framing_error;
    logic parity_error;
    logic [8:0] data;
  } uic_rx_entry_t;

  typedef enum logic [4:0] {
    TXS_IDLE = 5'b00001, TXS_START = 5'b00010, TXS_DATA = 5'b00100,
    TXS_PAR = 5'b01000, TXS_STOP = 5'b10000
  } uic_tx_state_t;

  typedef enum logic [4:0] {
    RXS_IDLE = 5'b00001, RXS_START = 5'b00010, RXS_DATA = 5'b00100,
    RXS_PAR = 5'b01000, RXS_STOP = 5'b10000
  } uic_rx_state_t;

endpackage : uic_pkg

// [hw/uic_uart.sv]
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module uic_uart #(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // apb slave
  input wire uic_pkg::uic_apb_t APB_REQ,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // system power state
  input wire logic IDLE_MODE,
  input wire logic SLEEP_MODE,
  // line pins
  input wire logic SERIAL_IN_PIN,
  output logic SERIAL_OUT_PIN,
  output logic SERIAL_OUT_OE,
  output logic REQUEST_TO_SEND_PIN_N,
  output logic REQUEST_TO_SEND_OE,
  input wire logic CLEAR_TO_SEND_PIN_N,
  // event pulses
  output logic TX_EVENT,
  output logic RX_EVENT,
  output logic WAKE_EVENT
);
  import uic_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);

  // parity bit over 8 or 9 data bits, even or odd
  function automatic logic par_of(input logic [8:0] d, input logic nine_b, input logic odd_b);
    par_of = ^(nine_b ? d : {1'b0, d[7:0]}) ^ odd_b;
  endfunction : par_of

  logic [15:0] mode; // serial_mode_control
  logic [15:0] sta_ctl; // writable half of serial_status_control
  logic [15:0] baud_div; // divisor
  logic overrun_error; // overrun flag
  logic [15:0] brg_cnt; // baud timer
  logic bclk; // registered baud tick clock for the pin (16x the bit rate, 4x in high speed)
  logic [8:0] tx_mem [FIFO_DEPTH];
  logic [PW-1:0] tx_wp, tx_rp;
  logic [PW:0] tx_cnt;
  uic_rx_entry_t rx_mem [FIFO_DEPTH];
  logic [PW-1:0] rx_wp, rx_rp;
  logic [PW:0] rx_cnt;
  uic_tx_state_t tx_state;
  logic [4:0] tx_os; // ticks inside current bit
  logic [3:0] tx_bit; // bit index
  logic [8:0] tx_sh; // transmit_shifter
  logic tx_pbit, tx_brk;
  uic_rx_state_t rx_state;
  logic [4:0] rx_os;
  logic [3:0] rx_bit;
  logic [8:0] rx_sh; // receive_shifter
  logic rx_parity_error;
  logic rx_line_q; // previous rx line for edges
  logic [4:0] ir_hold; // decoder stretch
  logic [2:0] ab_falls; // auto-baud edge count
  logic [23:0] ab_cnt; // auto-baud clock count
  logic wake_seen;

  // apb decode; the slave never waits
  wire setup = APB_REQ.psel & ~APB_REQ.penable;
  wire access = APB_REQ.psel & APB_REQ.penable;
  wire hit_mode = APB_REQ.paddr == OFF_MODE;
  wire hit_sta = APB_REQ.paddr == OFF_STATUS;
  wire hit_tx = APB_REQ.paddr == OFF_TXDATA;
  wire hit_rx = APB_REQ.paddr == OFF_RXDATA;
  wire hit_baud = APB_REQ.paddr == OFF_BAUD;
  wire mapped = hit_mode | hit_sta | hit_tx | hit_rx | hit_baud;
  wire wr = access & APB_REQ.pwrite;
  wire rd = access & ~APB_REQ.pwrite;
  wire [15:0] wdata = APB_REQ.pwdata[15:0];
  wire wr_mode = wr & hit_mode;
  wire wr_sta = wr & hit_sta;
  wire wr_tx = wr & hit_tx;
  wire wr_baud = wr & hit_baud;
  wire rd_rx = rd & hit_rx;

  // control fields
  wire en = mode[MODE_EN];
  wire run = en & ~(mode[MODE_SIDL] & IDLE_MODE);
  wire high_speed_select = mode[MODE_HIGH_SPEED_SELECT];
  wire ir_on = mode[MODE_INFRARED_CODEC_ENABLE] & ~high_speed_select;
  wire [1:0] parity_data_select = mode[MODE_PARITY_DATA_SELECT +: 2];
  wire nine = parity_data_select == 2'b11;
  wire par_on = parity_data_select == 2'b01 || parity_data_select == 2'b10;
  wire odd = parity_data_select == 2'b10;
  wire [1:0] pin_usage_select = mode[MODE_UEN +: 2];
  wire txen = sta_ctl[STA_TXEN];
  wire brk_req = sta_ctl[STA_BRK];
  wire [1:0] txisel = {sta_ctl[STA_TXISEL1], sta_ctl[STA_TXISEL0]};
  wire [1:0] rxisel = sta_ctl[STA_RXISEL +: 2];
  wire [4:0] os_last = (high_speed_select ? OS_HS : OS_STD) - 5'h01;

  // baud tick: timer reaching the divisor, frozen when halted
  wire tick = run & (brg_cnt == baud_div);

  // fifo status
  wire tx_empty = tx_cnt == '0;
  wire tx_full = tx_cnt == (PW+1)'(FIFO_DEPTH);
  wire rx_empty = rx_cnt == '0;
  wire rx_full = rx_cnt == (PW+1)'(FIFO_DEPTH);
  uic_rx_entry_t rx_head;
  assign rx_head = rx_mem[rx_rp];

  // transmit control decode
  wire cts_ok = (pin_usage_select != 2'b10) | ~CLEAR_TO_SEND_PIN_N;
  wire tx_load = run & txen & (tx_state == TXS_IDLE) & ~tx_empty & cts_ok;
  wire tx_bit_end = tick & (tx_os == os_last);
  wire [3:0] tx_last = tx_brk ? BREAK_BITS - 4'h1 : (nine ? 4'h8 : 4'h7);
  wire tx_stop_end = (tx_state == TXS_STOP) & tx_bit_end & (tx_bit == {3'b000, mode[MODE_STOP_BIT_SELECT]});
  wire txen_clr = wr_sta & txen & ~wdata[STA_TXEN];
  wire tx_flush = ~en | txen_clr;
  wire tx_push = wr_tx & en & ~tx_full;
  wire shifter_empty = (tx_state == TXS_IDLE) & tx_empty;
  wire brk_done = tx_stop_end & tx_brk;

  // frame line level before inversion or encoding
  logic tx_line;
  always_comb begin
    case (tx_state)
      TXS_START: tx_line = 1'b0;
      TXS_DATA: tx_line = tx_brk ? 1'b0 : tx_sh[0];
      TXS_PAR: tx_line = tx_pbit;
      default: tx_line = 1'b1;
    endcase
  end

  // pulse encoder: a short pulse in the head of each zero bit
  wire ir_tx_pulse = ~tx_line & (tx_os < IR_PULSE);
  wire next_serial_out = ir_on ? (ir_tx_pulse ^ sta_ctl[STA_TXINV])
                               : (tx_line ^ sta_ctl[STA_TXINV]);

  // receive line: loopback, decoder or plain pin, the pin inverted when receive inversion is set
  wire pin_level = SERIAL_IN_PIN ^ mode[MODE_RECEIVE_INVERSION];
  wire ir_pulse = ~pin_level;
  wire rx_line = mode[MODE_LOOPBACK_SELECT] ? tx_line
               : ir_on ? ~(ir_pulse | (ir_hold != 5'h00)) : pin_level;
  wire rx_fall = rx_line_q & ~rx_line;
  wire rx_rise = ~rx_line_q & rx_line;
  wire rx_bit_end = tick & (rx_os == os_last);
  wire [3:0] rx_last = nine ? 4'h8 : 4'h7;

  // receive push with address filter and overrun
  wire rx_frame_end = (rx_state == RXS_STOP) & rx_bit_end;
  wire rx_accept = ~(nine & sta_ctl[STA_ADDRESS_DETECT_ENABLE] & ~rx_sh[8]);
  wire rx_deliver = rx_frame_end & rx_accept;
  wire rx_ovf = rx_deliver & rx_full;
  wire rx_push = rx_deliver & ~rx_full;
  wire overrun_error_clr = wr_sta & overrun_error & ~wdata[STA_OVERRUN_ERROR];
  wire rx_flush = ~en | overrun_error_clr;
  wire rx_pop = rd_rx & ~rx_empty;

  // auto-baud measurement over the sync character's five falling edges
  wire ab_on = mode[MODE_AUTO_BAUD_ENABLE] & run;
  wire ab_done = ab_on & rx_fall & (ab_falls == SYNC_FALLS - 3'h1);
  wire [23:0] ab_per_tick = high_speed_select ? (ab_cnt >> 5) : (ab_cnt >> 7);
  wire [15:0] ab_div = (ab_per_tick > 24'h000000) ? ab_per_tick[15:0] - 16'h0001 : 16'h0000;

  // wake on start during sleep
  wire wake_fall = mode[MODE_WAKE] & SLEEP_MODE & rx_fall;
  wire wake_clr = wake_seen & rx_rise;

  // register next values; software writes win over hardware clears
  logic [15:0] next_mode, next_sta, next_baud;
  always_comb begin
    next_mode = mode;
    next_sta = sta_ctl;
    next_baud = baud_div;
    if (ab_done) next_mode[MODE_AUTO_BAUD_ENABLE] = 1'b0;
    if (wake_clr) next_mode[MODE_WAKE] = 1'b0;
    if (brk_done) next_sta[STA_BRK] = 1'b0;
    if (ab_done) next_baud = ab_div;
    if (wr_mode) next_mode = wdata & MODE_WMASK;
    if (wr_sta) next_sta = wdata & STA_WMASK;
    if (wr_baud) next_baud = wdata;
  end

  // control registers and overrun flag; a new overrun beats a clear
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode <= MODE_RST;
      sta_ctl <= STA_RST;
      baud_div <= BAUD_RST;
      overrun_error <= 1'b0;
    end else begin
      mode <= next_mode;
      sta_ctl <= next_sta;
      baud_div <= next_baud;
      overrun_error <= rx_ovf | (overrun_error & ~overrun_error_clr);
    end
  end

  // baud timer; cleared by a divisor write so the new rate starts at once
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      brg_cnt <= 16'h0000;
      bclk <= 1'b0;
    end else begin
      if (wr_baud | ~en) brg_cnt <= 16'h0000;
      else if (tick) brg_cnt <= 16'h0000;
      else if (run) brg_cnt <= brg_cnt + 16'h0001;
      bclk <= brg_cnt <= (baud_div >> 1);
    end
  end

  // transmit fifo; writes are taken even with transmit disabled
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else if (tx_flush) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else begin
      if (tx_push) tx_wp <= tx_wp + PW'(1);
      if (tx_load) tx_rp <= tx_rp + PW'(1);
      tx_cnt <= tx_cnt + (PW+1)'(tx_push) - (PW+1)'(tx_load);
    end
  end

  // fifo storage needs no reset; pointers guard it
  always_ff @(posedge CLOCK) begin
    if (tx_push) tx_mem[tx_wp] <= wdata[8:0];
    if (rx_push) rx_mem[rx_wp] <= '{framing_error: ~rx_line, parity_error: rx_parity_error, data: rx_sh};
  end

  // transmit shifter sequencer
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_state <= TXS_IDLE;
      tx_os <= 5'h00;
      tx_bit <= 4'h0;
      tx_sh <= 9'h000;
      tx_pbit <= 1'b0;
      tx_brk <= 1'b0;
    end else if (~en | ~txen) begin
      tx_state <= TXS_IDLE;
      tx_os <= 5'h00;
      tx_brk <= 1'b0;
    end else begin
      if (tick) tx_os <= (tx_os == os_last) ? 5'h00 : tx_os + 5'h01;
      case (tx_state)
        TXS_IDLE: begin
          if (tx_load) begin
            // a pending break swallows the dummy character
            tx_state <= TXS_START;
            tx_os <= 5'h00;
            tx_sh <= nine ? tx_mem[tx_rp] : {1'b0, tx_mem[tx_rp][7:0]};
            tx_pbit <= par_of(tx_mem[tx_rp], 1'b0, odd);
            tx_brk <= brk_req;
          end
        end
        TXS_START: begin
          if (tx_bit_end) begin
            tx_state <= TXS_DATA;
            tx_bit <= 4'h0;
          end
        end
        TXS_DATA: begin
          if (tx_bit_end) begin
            tx_sh <= tx_sh >> 1;
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == tx_last) begin
              tx_state <= (par_on & ~tx_brk) ? TXS_PAR : TXS_STOP;
              tx_bit <= 4'h0;
            end
          end
        end
        TXS_PAR: begin
          if (tx_bit_end) tx_state <= TXS_STOP;
        end
        TXS_STOP: begin
          if (tx_stop_end) begin
            tx_state <= TXS_IDLE;
            tx_brk <= 1'b0;
          end else if (tx_bit_end) begin
            tx_bit <= tx_bit + 4'h1;
          end
        end
        default: tx_state <= TXS_IDLE;
      endcase
    end
  end

  // receive fifo pointers
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else if (rx_flush) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else begin
      if (rx_push) rx_wp <= rx_wp + PW'(1);
      if (rx_pop) rx_rp <= rx_rp + PW'(1);
      rx_cnt <= rx_cnt + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
    end
  end

  // receive sequencer; samples mid-bit, checks only the first stop bit
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_state <= RXS_IDLE;
      rx_os <= 5'h00;
      rx_bit <= 4'h0;
      rx_sh <= 9'h000;
      rx_parity_error <= 1'b0;
    end else if (rx_flush) begin
      rx_state <= RXS_IDLE;
      rx_os <= 5'h00;
    end else begin
      if (tick) rx_os <= (rx_os == os_last) ? 5'h00 : rx_os + 5'h01;
      case (rx_state)
        RXS_IDLE: begin
          // no reception while measuring or while overrun stands
          if (run & rx_fall & ~mode[MODE_AUTO_BAUD_ENABLE] & ~overrun_error) begin
            rx_state <= RXS_START;
            rx_os <= 5'h00;
            rx_sh <= 9'h000;
            rx_parity_error <= 1'b0;
          end
        end
        RXS_START: begin
          if (tick & (rx_os == (os_last >> 1))) begin
            rx_os <= 5'h00;
            rx_bit <= 4'h0;
            rx_state <= rx_line ? RXS_IDLE : RXS_DATA; // glitch rejected
          end
        end
        RXS_DATA: begin
          if (rx_bit_end) begin
            rx_sh[rx_bit] <= rx_line;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == rx_last) rx_state <= par_on ? RXS_PAR : RXS_STOP;
          end
        end
        RXS_PAR: begin
          if (rx_bit_end) begin
            rx_parity_error <= rx_line ^ par_of(rx_sh, 1'b0, odd);
            rx_state <= RXS_STOP;
          end
        end
        RXS_STOP: begin
          if (rx_frame_end) rx_state <= RXS_IDLE;
        end
        default: rx_state <= RXS_IDLE;
      endcase
    end
  end

  // line history, decoder stretch, auto-baud and wake tracking
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_line_q <= 1'b1;
      ir_hold <= 5'h00;
      ab_falls <= 3'h0;
      ab_cnt <= 24'h000000;
      wake_seen <= 1'b0;
    end else begin
      rx_line_q <= rx_line;
      if (ir_pulse) ir_hold <= os_last; // stretch a pulse over one bit
      else if (tick & (ir_hold != 5'h00)) ir_hold <= ir_hold - 5'h01;
      if (~ab_on | ab_done) begin
        ab_falls <= 3'h0;
        ab_cnt <= 24'h000000;
      end else begin
        if (rx_fall) ab_falls <= ab_falls + 3'h1;
        if (ab_falls != 3'h0) ab_cnt <= ab_cnt + 24'h000001;
      end
      if (wake_fall) wake_seen <= 1'b1;
      else if (wake_clr | ~mode[MODE_WAKE]) wake_seen <= 1'b0;
    end
  end

  // event selection
  wire tx_evt = (txisel == 2'b00) ? tx_load
              : (txisel == 2'b01) ? (tx_stop_end & tx_empty)
              : (txisel == 2'b10) ? (tx_load & (tx_cnt == (PW+1)'(1))) : 1'b0;
  wire rx_evt = ~rxisel[1] ? rx_push
              : rxisel[0] ? (rx_push & (rx_cnt == (PW+1)'(FIFO_DEPTH - 1)))
              : (rx_push & (rx_cnt == (PW+1)'(FIFO_DEPTH * 3 / 4 - 1)));

  // status read value
  wire [15:0] sta_rd = {sta_ctl[15:13], 1'b0, sta_ctl[11:10], tx_full, shifter_empty,
                        sta_ctl[7:5], rx_state == RXS_IDLE,
                        rx_head.parity_error & ~rx_empty, rx_head.framing_error & ~rx_empty,
                        overrun_error, ~rx_empty};
  wire [15:0] rd_val = hit_mode ? mode
                     : hit_sta ? sta_rd
                     : hit_rx ? {7'h00, rx_empty ? 9'h000 : rx_head.data}
                     : hit_baud ? baud_div : 16'h0000;

  // rts either follows receive room or transmit activity
  wire rts_assert = mode[MODE_RTS_MODE_SELECT] ? ~shifter_empty : ~rx_full;

  // apb answers at once; write data and read side effects land in the access cycle
  assign PREADY = 1'b1;
  assign PSLVERR = access & ~mapped;

  // registered outputs
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PRDATA <= 32'h00000000;
      SERIAL_OUT_PIN <= 1'b1;
      SERIAL_OUT_OE <= 1'b0;
      REQUEST_TO_SEND_PIN_N <= 1'b1;
      REQUEST_TO_SEND_OE <= 1'b0;
      TX_EVENT <= 1'b0;
      RX_EVENT <= 1'b0;
      WAKE_EVENT <= 1'b0;
    end else begin
      if (setup) PRDATA <= {16'h0000, rd_val};
      SERIAL_OUT_PIN <= next_serial_out;
      SERIAL_OUT_OE <= en & txen;
      REQUEST_TO_SEND_PIN_N <= (pin_usage_select == 2'b11) ? bclk : ~rts_assert;
      REQUEST_TO_SEND_OE <= en & (pin_usage_select != 2'b00);
      TX_EVENT <= tx_evt;
      RX_EVENT <= rx_evt;
      WAKE_EVENT <= wake_fall;
    end
  end

endmodule : uic_uart

// [testbench/uic_monitor.sv]
`timescale 1ns/1ps
module uic_monitor (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // apb side
  input wire uic_pkg::uic_apb_t APB_REQ,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // power state and line
  input wire logic IDLE_MODE,
  input wire logic SLEEP_MODE,
  input wire logic SERIAL_OUT_PIN,
  input wire logic SERIAL_OUT_OE,
  input wire logic REQUEST_TO_SEND_OE,
  // events
  input wire logic TX_EVENT,
  input wire logic RX_EVENT,
  input wire logic WAKE_EVENT
);
  import uic_pkg::*;
  logic wr; // write completing at this edge
  logic mapped; // address hits a register
  logic en, sidl, txen; // shadow of software control bits
  logic [1:0] pin_usage_select; // shadow pin usage
  assign wr = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
  assign mapped = APB_REQ.paddr inside {OFF_MODE, OFF_STATUS, OFF_TXDATA, OFF_RXDATA, OFF_BAUD};
  // hardware never clears these bits, so a shadow built from writes stays exact
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      en <= 1'b0;
      sidl <= 1'b0;
      pin_usage_select <= 2'h0;
      txen <= 1'b0;
    end else if (wr && APB_REQ.paddr == OFF_MODE) begin
      en <= APB_REQ.pwdata[MODE_EN];
      sidl <= APB_REQ.pwdata[MODE_SIDL];
      pin_usage_select <= APB_REQ.pwdata[MODE_UEN +: 2];
    end else if (wr && APB_REQ.paddr == OFF_STATUS) begin
      txen <= APB_REQ.pwdata[STA_TXEN];
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  AST_PREADY: assert property (PREADY)
    else $error("pready low");
  AST_SLVERR: assert property (PSLVERR == (APB_REQ.psel && APB_REQ.penable && !mapped))
    else $error("slave error wrong");
  AST_TX_OE: assert property (SERIAL_OUT_OE == $past(en && txen))
    else $error("tx enable wrong");
  AST_RTS_OE: assert property (REQUEST_TO_SEND_OE == $past(en && pin_usage_select != 2'h0))
    else $error("rts enable wrong");
  AST_TX_PULSE: assert property (TX_EVENT |=> !TX_EVENT)
    else $error("tx event too long");
  AST_RX_PULSE: assert property (RX_EVENT |=> !RX_EVENT)
    else $error("rx event too long");
  AST_WAKE: assert property (WAKE_EVENT |-> $past(SLEEP_MODE) ##1 !WAKE_EVENT)
    else $error("wake event wrong");
  AST_OFF_QUIET: assert property (!en [*3] |-> !TX_EVENT && !RX_EVENT)
    else $error("event while disabled");
  AST_FREEZE: assert property ((en && sidl && IDLE_MODE) [*3] |-> $stable(SERIAL_OUT_PIN))
    else $error("line moved in idle");
  COV_TX: cover property (TX_EVENT);
  COV_RX: cover property (RX_EVENT);
  COV_WAKE: cover property (WAKE_EVENT);
endmodule : uic_monitor

bind uic_uart uic_monitor mon (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .APB_REQ(APB_REQ),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .IDLE_MODE(IDLE_MODE), .SLEEP_MODE(SLEEP_MODE),
  .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .SERIAL_OUT_OE(SERIAL_OUT_OE),
  .REQUEST_TO_SEND_OE(REQUEST_TO_SEND_OE), .TX_EVENT(TX_EVENT), .RX_EVENT(RX_EVENT),
  .WAKE_EVENT(WAKE_EVENT));

// [testbench/uic_remote.sv]
`timescale 1ns/1ps
module uic_remote (
  // clock
  input wire logic clk,
  // line
  input wire logic from_dut,
  output logic to_dut,
  // clocks per bit
  input wire logic [7:0] bit_clks
);
  logic [7:0] rxq[$]; // bytes heard from the device
  logic [7:0] rx_byte; // byte being assembled
  initial to_dut = 1'b1;
  // one 8n1 frame: start low, lsb first, stop high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      to_dut <= f[i];
      repeat (bit_clks) @(posedge clk);
    end
  endtask : send
  // sample mid-bit after the start edge; stop level not checked here
  always begin
    @(negedge from_dut);
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge clk);
      rx_byte[i] = from_dut;
    end
    repeat (bit_clks) @(posedge clk);
    rxq.push_back(rx_byte);
  end
endmodule : uic_remote

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import uic_pkg::*;
  logic clk = 1'b0, rst = 1'b1, idle = 1'b0, sleep = 1'b0, err;
  uic_apb_t req = '0;
  logic [31:0] prdata, q, seed = 32'h9677248b;
  logic pready, pslverr, tx, rx_line, rx_ev, wake_ev;
  logic [7:0] bclk = 8'h10; // clocks per bit for the remote end
  int n_mismatch = 0, n_compared = 0, n_wake = 0;
  always #5 clk = ~clk;
  uic_uart DUT (.CLOCK(clk), .SYS_RST(rst), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IDLE_MODE(idle), .SLEEP_MODE(sleep), .SERIAL_IN_PIN(rx_line),
    .SERIAL_OUT_PIN(tx), .SERIAL_OUT_OE(), .REQUEST_TO_SEND_PIN_N(),
    .REQUEST_TO_SEND_OE(), .CLEAR_TO_SEND_PIN_N(1'b1), .TX_EVENT(), .RX_EVENT(rx_ev),
    .WAKE_EVENT(wake_ev));
  uic_remote far (.clk(clk), .from_dut(tx), .to_dut(rx_line), .bit_clks(bclk));
  always @(posedge clk) if (wake_ev === 1'b1) n_wake++;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  // status word from flags; receiver idle expected whenever we read
  function automatic logic [31:0] sta(input logic txen, full, mt, av, oe);
    return {16'h0, 5'h0, txen, full, mt, 3'h0, 1'b1, 2'h0, oe, av};
  endfunction : sta
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    req <= '0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask : rd
  task automatic wait_rx(input int n);
    for (int i = 0; i < 20000 && far.rxq.size() < n; i++) @(posedge clk);
  endtask : wait_rx
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    logic [7:0] b[5];
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_MODE, 32'h0, "mode reset");
    rd(OFF_STATUS, sta(0, 0, 1, 0, 0), "status reset");
    apb(1'b1, 8'h14, 32'h1234);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test reset done");
    apb(1'b1, OFF_BAUD, 32'h0);
    apb(1'b1, OFF_MODE, 32'h8000);
    apb(1'b1, OFF_STATUS, 32'h0400);
    for (int i = 0; i < 5; i++) begin
      b[i] = rnd();
      apb(1'b1, OFF_TXDATA, {24'h0, b[i]});
    end
    rd(OFF_STATUS, sta(1, 1, 0, 0, 0), "tx full");
    wait_rx(5);
    repeat (32) @(posedge clk);
    foreach (b[i]) chk("tx byte", {24'h0, b[i]}, {24'h0, far.rxq.pop_front()});
    rd(OFF_STATUS, sta(1, 0, 1, 0, 0), "tx drained");
    $display("test transmit done");
    for (int i = 0; i < 4; i++) begin
      b[i] = rnd();
      far.send(b[i]);
    end
    repeat (16) @(posedge clk);
    rd(OFF_STATUS, sta(1, 0, 1, 1, 0), "rx avail");
    for (int i = 0; i < 4; i++) rd(OFF_RXDATA, {24'h0, b[i]}, "rx byte");
    rd(OFF_STATUS, sta(1, 0, 1, 0, 0), "rx empty");
    for (int i = 0; i < 5; i++) far.send(rnd());
    repeat (16) @(posedge clk);
    rd(OFF_STATUS, sta(1, 0, 1, 1, 1), "overrun");
    apb(1'b1, OFF_STATUS, 32'h0400);
    rd(OFF_STATUS, sta(1, 0, 1, 0, 0), "overrun clear");
    $display("test receive done");
    bclk <= 8'h0c;
    apb(1'b1, OFF_BAUD, 32'h2);
    apb(1'b1, OFF_MODE, 32'h8008);
    b[0] = rnd();
    far.send(b[0]);
    repeat (12) @(posedge clk);
    rd(OFF_RXDATA, {24'h0, b[0]}, "fast rx");
    apb(1'b1, OFF_TXDATA, {24'h0, b[0]});
    wait_rx(1);
    chk("fast tx", {24'h0, b[0]}, {24'h0, far.rxq.pop_front()});
    $display("test high speed done");
    apb(1'b1, OFF_MODE, 32'h8148);
    b[1] = rnd();
    apb(1'b1, OFF_TXDATA, {24'h0, b[1]});
    repeat (144) @(posedge clk);
    rd(OFF_RXDATA, {24'h0, b[1]}, "loopback");
    // nine data bits through the loop, ninth bit set
    apb(1'b1, OFF_MODE, 32'h814e);
    b[2] = rnd();
    apb(1'b1, OFF_TXDATA, {23'h0, 1'b1, b[2]});
    repeat (160) @(posedge clk);
    rd(OFF_RXDATA, {23'h0, 1'b1, b[2]}, "ninth bit");
    // even parity through the loop: no parity error on the head
    apb(1'b1, OFF_MODE, 32'h814a);
    b[3] = rnd();
    apb(1'b1, OFF_TXDATA, {24'h0, b[3]});
    repeat (160) @(posedge clk);
    rd(OFF_STATUS, sta(1, 0, 1, 1, 0), "parity clean");
    rd(OFF_RXDATA, {24'h0, b[3]}, "parity data");
    $display("test loopback done");
    apb(1'b1, OFF_MODE, 32'ha088);
    sleep <= 1'b1;
    far.send(rnd());
    sleep <= 1'b0;
    chk("wake seen", 32'h1, {31'h0, n_wake > 0});
    rd(OFF_MODE, 32'ha008, "wake cleared");
    idle <= 1'b1;
    repeat (20) @(posedge clk);
    idle <= 1'b0;
    $display("test wake and idle done");
    wrap_up();
  end
  // cut a hang short
  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
endmodule : testbench
